// file: hdl/fei_pkg.sv
// Constants shared by the fault event interrupt unit
package fei_pkg;
	localparam int FEI_NUM_EVENTS = 5;
	localparam logic [7:0] FEI_ADDR_FLAGS = 8'h02;
	localparam logic [7:0] FEI_ADDR_ENABLE = 8'h03;
	localparam int FEI_BIT_LIGHT1 = 0;
	localparam int FEI_BIT_LIGHT2 = 1;
	localparam int FEI_BIT_OVERVOLT = 2;
	localparam int FEI_BIT_OVERTEMP = 3;
	localparam int FEI_BIT_SHORT = 4;
	localparam logic [4:0] FEI_FLAGS_RESET = 5'h00;
	localparam logic [4:0] FEI_ENABLE_RESET = 5'h00;
	localparam int FEI_CLK_HZ = 20000000;
	localparam int FEI_GAP_US = 50;
	localparam int FEI_GAP_CYCLES = FEI_GAP_US * (FEI_CLK_HZ / 1000000);
	localparam int FEI_GAP_W = 11;
	localparam logic [FEI_GAP_W-1:0] FEI_GAP_LAST = FEI_GAP_W'(FEI_GAP_CYCLES - 1);
	localparam logic [FEI_GAP_W-1:0] FEI_GAP_ZERO = 11'h000;
endpackage : fei_pkg

// file: hdl/fei_evt_if.sv
// Carrier between the flag bank and the interrupt logic
`timescale 1ns/1ps
interface fei_evt_if;
	logic [4:0] flags;
	logic [4:0] enable;
	logic clear_hit;
	modport bank (output flags, output enable, output clear_hit);
	modport user (input flags, input enable, input clear_hit);
endinterface : fei_evt_if

// file: hdl/fei_flag_bank.sv
// Sticky event flags with write-one-to-clear and the enable register
`timescale 1ns/1ps
module fei_flag_bank
	import fei_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic [4:0] set_in,
	input wire logic wr_flags_in,
	input wire logic wr_enable_in,
	input wire logic [7:0] wdata_in,
	fei_evt_if.bank evt
);
	logic [4:0] flags;
	logic [4:0] enable;

	// Sticky flag, enable ignored
	// Each bit keeps its own flip-flop so no variable has two writing processes
	genvar gi;
	generate
		for (gi = 0; gi < FEI_NUM_EVENTS; gi++)
		begin : g_flag
			logic flag_bit;
			always_ff @(posedge ref_clk_in)
			begin
				if (!rstn_in)
					flag_bit <= FEI_FLAGS_RESET[gi];
				else if (set_in[gi])
					flag_bit <= 1'b1;
				else if (wr_flags_in && wdata_in[gi])
					flag_bit <= 1'b0;
			end
			assign flags[gi] = flag_bit;
		end
	endgenerate

	always_ff @(posedge ref_clk_in)
	begin
		if (!rstn_in)
			enable <= FEI_ENABLE_RESET;
		else if (wr_enable_in)
			enable <= wdata_in[4:0];
	end

	assign evt.flags = flags;
	assign evt.enable = enable;
	assign evt.clear_hit = wr_flags_in && ((wdata_in[4:0] & flags) != 5'h00);

	AST_CLEAR_W1C: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(flags[0] && !(wr_flags_in && wdata_in[0])) |=> flags[0])
		else $error("flag 0 lost without a write of one");
	AST_SET_NO_ENABLE: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		set_in[FEI_BIT_SHORT] |=> flags[FEI_BIT_SHORT])
		else $error("short flag not set by its event");
endmodule : fei_flag_bank

// file: hdl/fei_fault_event_irq.sv
// Top of the fault event interrupt unit: event capture, register port, host interrupt
`timescale 1ns/1ps
// What this block does
// - Short or overload sets bit 4
// - Overtemperature sets bit 3
// - Overvoltage sets bit 2
// - Second light comparator change sets bit 1
// - Main light comparator change sets bit 0
// - Flags clear only on write one
// - Interrupt needs matching enable bit
// - Disabled flags still set and hold
// - Light flags need enabled comparator whose output changes, either way
// - Config one: 50 us release, then reassert
// - Config zero: interrupt stays asserted, with no release, while any enabled flag is set
module fei_fault_event_irq
	import fei_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic short_detect_in,
	input wire logic overtemp_detect_in,
	input wire logic overvolt_detect_in,
	input wire logic light1_cmp_enable_in,
	input wire logic light1_cmp_out_in,
	input wire logic light2_cmp_enable_in,
	input wire logic light2_cmp_out_in,
	input wire logic irq_pulse_cfg_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic host_irq_n_out
);
	fei_evt_if evt ();
	logic light1_prev;
	logic light2_prev;
	logic [4:0] set_vec;
	logic wr_flags;
	logic wr_enable;
	logic pending;
	logic [FEI_GAP_W-1:0] gap_cnt;
	logic gap_active;

	// ****************************************
	// Event capture
	// ****************************************
	// History follows the pin every cycle, also in reset, so neither reset release
	// nor enabling a comparator that already sits high is taken as a change
	always_ff @(posedge ref_clk_in)
	begin
		light1_prev <= light1_cmp_out_in;
		light2_prev <= light2_cmp_out_in;
	end

	always_comb
	begin
		set_vec = 5'h00;
		set_vec[FEI_BIT_SHORT] = short_detect_in;
		set_vec[FEI_BIT_OVERTEMP] = overtemp_detect_in;
		set_vec[FEI_BIT_OVERVOLT] = overvolt_detect_in;
		set_vec[FEI_BIT_LIGHT2] = light2_cmp_enable_in && (light2_cmp_out_in != light2_prev);
		set_vec[FEI_BIT_LIGHT1] = light1_cmp_enable_in && (light1_cmp_out_in != light1_prev);
	end

	// ****************************************
	// Register port
	// ****************************************
	assign wr_flags = reg_wr_in && (reg_addr_in == FEI_ADDR_FLAGS);
	assign wr_enable = reg_wr_in && (reg_addr_in == FEI_ADDR_ENABLE);

	fei_flag_bank u_bank (
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in),
		.set_in(set_vec),
		.wr_flags_in(wr_flags),
		.wr_enable_in(wr_enable),
		.wdata_in(reg_wdata_in),
		.evt(evt.bank)
	);

	// Reads have no side effect; reserved bits and unmapped offsets read zero
	always_ff @(posedge ref_clk_in)
	begin
		if (!rstn_in)
			reg_rdata_out <= 8'h00;
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
				FEI_ADDR_FLAGS: reg_rdata_out <= {3'h0, evt.flags};
				FEI_ADDR_ENABLE: reg_rdata_out <= {3'h0, evt.enable};
				default: reg_rdata_out <= 8'h00;
			endcase
		end
	end

	// ****************************************
	// Host interrupt
	// ****************************************
	// Masked pending events
	assign pending = (evt.flags & evt.enable) != 5'h00;

	always_ff @(posedge ref_clk_in)
	begin
		if (!rstn_in)
			gap_cnt <= FEI_GAP_ZERO;
		else if (irq_pulse_cfg_in && evt.clear_hit && !host_irq_n_out)
			gap_cnt <= FEI_GAP_LAST;
		else if (gap_cnt != FEI_GAP_ZERO)
			gap_cnt <= gap_cnt - FEI_GAP_W'(1);
	end
	assign gap_active = (gap_cnt != FEI_GAP_ZERO);

	// Line follows pending unless in gap
	// The gap is started from the clear write itself, so it costs exactly 1000 cycles high
	always_ff @(posedge ref_clk_in)
	begin
		if (!rstn_in)
			host_irq_n_out <= 1'b1;
		else if (irq_pulse_cfg_in && evt.clear_hit && !host_irq_n_out)
			host_irq_n_out <= 1'b1;
		else
			host_irq_n_out <= !(pending && !gap_active);
	end

	// ****************************************
	// Checks
	// ****************************************
	// Line tracks masked flags
	AST_IRQ_TRACKS: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(!irq_pulse_cfg_in && !evt.clear_hit && !gap_active)
			|=> (host_irq_n_out == !$past(pending)))
		else $error("interrupt line does not follow masked flags");
	AST_MASKED: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(evt.enable == 5'h00) |=> host_irq_n_out)
		else $error("interrupt raised with all enables clear");
	AST_GAP_HIGH: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(irq_pulse_cfg_in && evt.clear_hit && !host_irq_n_out) |=> host_irq_n_out [*8])
		else $error("interrupt not released after clear");
	AST_GAP_LEN: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(irq_pulse_cfg_in && evt.clear_hit && !host_irq_n_out) |=> (gap_cnt == FEI_GAP_LAST))
		else $error("gap counter not loaded with the gap length");
	AST_NO_BREAK: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(!irq_pulse_cfg_in && evt.clear_hit && !gap_active
			&& ((evt.flags & ~reg_wdata_in[4:0] & evt.enable) != 5'h00))
			|=> !host_irq_n_out)
		else $error("interrupt broke while events pending");
	AST_LIGHT1: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(light1_cmp_enable_in && $changed(light1_cmp_out_in) && $past(light1_cmp_enable_in))
			|=> evt.flags[FEI_BIT_LIGHT1])
		else $error("main comparator change not flagged");
	AST_LIGHT2: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(light2_cmp_enable_in && $changed(light2_cmp_out_in) && $past(light2_cmp_enable_in))
			|=> evt.flags[FEI_BIT_LIGHT2])
		else $error("second comparator change not flagged");
	AST_CMP_GATED: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(!light1_cmp_enable_in && !evt.flags[FEI_BIT_LIGHT1]) |=> !evt.flags[FEI_BIT_LIGHT1])
		else $error("disabled comparator set its flag");
	AST_OVERTEMP: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		overtemp_detect_in |=> evt.flags[FEI_BIT_OVERTEMP])
		else $error("overtemperature not flagged");
	AST_OVERVOLT: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		overvolt_detect_in |=> evt.flags[FEI_BIT_OVERVOLT])
		else $error("overvoltage not flagged");
	AST_SHORT: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		short_detect_in |=> evt.flags[FEI_BIT_SHORT])
		else $error("short not flagged");
endmodule : fei_fault_event_irq

// file: test/fei_host_model.sv
// Host processor model on the register port
`timescale 1ns/1ps
module fei_host_model (
	input wire logic clk_in,
	output logic [7:0] addr_out,
	output logic wr_out,
	output logic rd_out,
	output logic [7:0] wdata_out
);
	initial
	begin
		addr_out = 8'hFF;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 8'h00;
	end
	task acc(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= w;
		rd_out <= ~w;
		@(posedge clk_in);
		// Released bus shows the inverse so stale values never match
		addr_out <= ~a;
		wdata_out <= ~d;
		wr_out <= 1'b0;
		rd_out <= 1'b0;
	endtask : acc
endmodule : fei_host_model

// file: test/tb_top.sv
// Self-checking bench for the fault event interrupt unit
`timescale 1ns/1ps
module tb_top;
	import fei_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic shrt = 1'b0, ovt = 1'b0, ovv = 1'b0, cfg = 1'b0;
	logic l1en = 1'b0, l1out = 1'b0, l2en = 1'b0, l2out = 1'b0;
	logic [7:0] addr, wdata, rdata, exp, en;
	logic wr, rd, irq_n, rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	int n_errors = 0, total_checks = 0, cycles = 0;
	fei_host_model host (.clk_in(clk), .addr_out(addr), .wr_out(wr), .rd_out(rd),
		.wdata_out(wdata));
	fei_fault_event_irq DUT (.ref_clk_in(clk), .rstn_in(rstn), .short_detect_in(shrt),
		.overtemp_detect_in(ovt), .overvolt_detect_in(ovv), .light1_cmp_enable_in(l1en),
		.light1_cmp_out_in(l1out), .light2_cmp_enable_in(l2en), .light2_cmp_out_in(l2out),
		.irq_pulse_cfg_in(cfg), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_wdata_in(wdata), .reg_rdata_out(rdata), .host_irq_n_out(irq_n));
	initial
	begin
		forever #25 clk = ~clk;
	end
	task wrap_up;
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task rd_chk(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.acc(a, 8'h00, 1'b0);
	endtask : rd_chk
	task chk(input logic e);
		total_checks++;
		if (irq_n !== e)
		begin
			$display("ERROR host_irq_n_out expected %b seen %b", e, irq_n);
			n_errors++;
		end
	endtask : chk
	task ev(input int i);
		@(posedge clk);
		case (i)
			0: l1out <= ~l1out;
			1: l2out <= ~l2out;
			2: ovv <= 1'b1;
			3: ovt <= 1'b1;
			default: shrt <= 1'b1;
		endcase
		@(posedge clk);
		{shrt, ovt, ovv} <= 3'h0;
	endtask : ev
	// Read results land one cycle after the strobe edge
	always @(posedge clk)
	begin
		if (rd_seen)
		begin
			exp = exp_q.pop_front();
			total_checks++;
			if (rdata !== exp)
			begin
				$display("ERROR reg_rdata_out expected %h seen %h", exp, rdata);
				n_errors++;
			end
		end
		rd_seen <= rd;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_errors++;
			wrap_up();
		end
	end
	initial
	begin
		void'($urandom(31));
		cyc(16);
		rstn <= 1'b1;
		host.acc(8'h05, 8'hFF, 1'b1);
		rd_chk(FEI_ADDR_FLAGS, 8'h00);
		rd_chk(FEI_ADDR_ENABLE, 8'h00);
		rd_chk(8'h05, 8'h00);
		ev(0);
		ev(0);
		ev(1);
		ev(1);
		cyc(3);
		rd_chk(FEI_ADDR_FLAGS, 8'h00);
		l1en <= 1'b1;
		l2en <= 1'b1;
		for (int i = 0; i < FEI_NUM_EVENTS; i++)
		begin
			ev(i);
			cyc(3);
			chk(1'b1);
			rd_chk(FEI_ADDR_FLAGS, 8'h01 << i);
			host.acc(FEI_ADDR_FLAGS, ~(8'h01 << i), 1'b1);
			rd_chk(FEI_ADDR_FLAGS, 8'h01 << i);
			host.acc(FEI_ADDR_FLAGS, 8'h01 << i, 1'b1);
			rd_chk(FEI_ADDR_FLAGS, 8'h00);
		end
		for (int k = 0; k < 4; k++)
		begin
			en = 8'($urandom);
			host.acc(FEI_ADDR_ENABLE, en, 1'b1);
			rd_chk(FEI_ADDR_ENABLE, en & 8'h1F);
			for (int i = 0; i < FEI_NUM_EVENTS; i++)
				ev(i);
			cyc(3);
			chk(~|en[4:0]);
			host.acc(FEI_ADDR_FLAGS, 8'h1F, 1'b1);
			cyc(3);
			chk(1'b1);
		end
		@(posedge clk);
		cfg <= 1'b1;
		host.acc(FEI_ADDR_ENABLE, 8'h1F, 1'b1);
		ev(4);
		ev(3);
		cyc(3);
		chk(1'b0);
		host.acc(FEI_ADDR_FLAGS, 8'h10, 1'b1);
		cyc(3);
		chk(1'b1);
		cyc(997);
		chk(1'b1);
		@(posedge clk);
		chk(1'b0);
		cfg <= 1'b0;
		ev(2);
		host.acc(FEI_ADDR_FLAGS, 8'h08, 1'b1);
		repeat (6)
		begin
			@(posedge clk);
			chk(1'b0);
		end
		host.acc(FEI_ADDR_FLAGS, 8'h1F, 1'b1);
		cyc(3);
		chk(1'b1);
		wrap_up();
	end
endmodule : tb_top
